/* src/pfh_host.sv */
// Purpose: host controller driving an asynchronous page-mode NOR flash
// Assumes: flash pins synchronous to clk; one request at a time
// Notes: commands (program, erase, autoselect, bypass) are word writes by the user
`default_nettype none

module pfh_host
	import pfh_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic reset, // async reset, active high
	input wire logic req_valid, // request offered
	output logic req_ready, // request taken
	input wire pfh_req_t req, // operation, address, data
	input wire logic dual_enable, // device has two half enables
	input wire logic accel_request, // user wants accelerated program
	output logic rsp_valid, // read data valid, one cycle
	output logic [DATA_W-1:0] rsp_data, // read data
	output logic flash_busy, // ready_busy_n seen low
	output logic [1:0] cur_bank, // bank of last access
	output logic [ADDR_W-1:0] addr_out, // flash address pins
	output logic chip_enable_n, // single enable / unused in dual
	output logic lower_half_enable_n, // dual lower half enable
	output logic upper_half_enable_n, // dual upper half enable
	output logic output_enable_n, // flash oe
	output logic write_enable_n, // flash we
	output logic reset_n, // flash hardware reset
	output logic accel_enable, // select accel_high_voltage on protect_accel_pin
	input wire logic [DATA_W-1:0] data_pins_in, // data pins in
	output logic [DATA_W-1:0] data_pins_out, // data pins out
	output logic data_pins_oe, // data pins driven
	input wire logic ready_busy_n // open-drain ready/busy
);
	typedef enum {
		ST_START,
		ST_RESET_PULSE,
		ST_RECOVER,
		ST_IDLE,
		ST_READ,
		ST_WRITE,
		ST_WRITE_END
	} pfh_state_t;

	pfh_state_t state, next_state;
	pfh_ctl_t ctl, next_ctl;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] wdata;
	logic page_open;
	logic [ADDR_W-PAGE_BITS-1:0] open_page;
	logic tmr_load;
	logic [CNT_W-1:0] tmr_cycles;
	logic tmr_done;
	logic page_hit;
	logic take;
	logic half_sel;

	function automatic logic [1:0] bank_of(input logic dual, input logic [2:0] top);
		if (!dual) begin
			unique case (top)
				3'h0: bank_of = PFH_BANK_A;
				3'h1, 3'h2, 3'h3: bank_of = PFH_BANK_B;
				3'h4, 3'h5, 3'h6: bank_of = PFH_BANK_C;
				default: bank_of = PFH_BANK_D;
			endcase
		end else if (!top[2]) begin
			bank_of = (top[1:0] == 2'h0) ? PFH_BANK_A : PFH_BANK_B;
		end else begin
			bank_of = (top[1:0] == 2'h3) ? PFH_BANK_D : PFH_BANK_C;
		end
	endfunction : bank_of

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// page hit only while enable stayed low since the last read
	assign page_hit = page_open && (req.addr[ADDR_W-1:PAGE_BITS] == open_page);
	assign take = (state == ST_IDLE) && req_valid;
	assign req_ready = take;
	// in dual mode the top bit picks the half
	assign half_sel = addr_out[ADDR_W-1];
	assign chip_enable_n = ctl.chip_enable_n;
	assign lower_half_enable_n = ctl.chip_enable_n | (dual_enable & half_sel);
	assign upper_half_enable_n = ctl.chip_enable_n | ~dual_enable | ~half_sel;
	assign output_enable_n = ctl.output_enable_n;
	assign write_enable_n = ctl.write_enable_n;
	assign reset_n = ctl.reset_n;
	assign data_pins_out = wdata;
	// data bus driven only while oe is high, avoiding contention
	assign data_pins_oe = (state == ST_WRITE) || (state == ST_WRITE_END);
	assign flash_busy = ~ready_busy_n;

	pfh_timer u_timer (
		.clk(clk),
		.reset(reset),
		.load(tmr_load),
		.cycles(tmr_cycles),
		.done(tmr_done)
	);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_ctl = ctl;
		next_addr = addr_out;
		tmr_load = 1'b0;
		tmr_cycles = '0;
		unique case (state)
			ST_START: begin
				// the timer is clear after reset, so the pulse length is loaded here
				tmr_load = 1'b1;
				tmr_cycles = CNT_W'(RP_CYC);
				next_state = ST_RESET_PULSE;
			end
			ST_RESET_PULSE: begin
				if (tmr_done) begin
					next_ctl.reset_n = 1'b1;
					tmr_load = 1'b1;
					tmr_cycles = CNT_W'(RH_CYC);
					next_state = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				// flash is in read-array now, no command needed
				if (tmr_done && ready_busy_n) begin
					next_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				next_ctl.output_enable_n = 1'b1;
				next_ctl.write_enable_n = 1'b1;
				if (take) begin
					next_addr = req.addr;
					unique case (req.op)
						PFH_OP_READ: begin
							next_ctl.chip_enable_n = 1'b0;
							next_ctl.output_enable_n = 1'b0;
							tmr_load = 1'b1;
							// full time after standby or a new page
							tmr_cycles = page_hit ? CNT_W'(PACC_CYC) : CNT_W'(CE_CYC);
							next_state = ST_READ;
						end
						PFH_OP_WRITE: begin
							next_ctl.chip_enable_n = 1'b0;
							next_ctl.write_enable_n = 1'b0;
							tmr_load = 1'b1;
							tmr_cycles = CNT_W'(WP_CYC);
							next_state = ST_WRITE;
						end
						default: begin
							next_ctl.reset_n = 1'b0;
							next_ctl.chip_enable_n = 1'b1;
							tmr_load = 1'b1;
							tmr_cycles = CNT_W'(RP_CYC);
							next_state = ST_RESET_PULSE;
						end
					endcase
				end else if (!req_valid) begin
					// release enable when idle; the flash keeps any
					// embedded operation running
					next_ctl.chip_enable_n = 1'b1;
				end
			end
			ST_READ: begin
				if (tmr_done) begin
					next_ctl.output_enable_n = 1'b1;
					next_state = ST_IDLE;
				end
			end
			ST_WRITE: begin
				if (tmr_done) begin
					next_ctl.write_enable_n = 1'b1;
					next_state = ST_WRITE_END;
				end
			end
			ST_WRITE_END: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= ST_START;
			ctl <= '{chip_enable_n: 1'b1, output_enable_n: 1'b1,
				write_enable_n: 1'b1, reset_n: 1'b0};
			addr_out <= '0;
		end else begin
			state <= next_state;
			ctl <= next_ctl;
			addr_out <= next_addr;
		end
	end

	// ------------------------------------------------------------
	// data path and page tracking
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wdata <= '0;
			rsp_valid <= 1'b0;
			rsp_data <= '0;
			page_open <= 1'b0;
			open_page <= '0;
			cur_bank <= 2'h0;
			accel_enable <= 1'b0;
		end else begin
			// accel only raised on request, never while the flash is held in reset
			accel_enable <= accel_request && next_ctl.reset_n;
			rsp_valid <= (state == ST_READ) && tmr_done;
			if ((state == ST_READ) && tmr_done) begin
				// latched data stays valid through sleep
				rsp_data <= data_pins_in;
			end
			if (take) begin
				wdata <= req.wdata;
				cur_bank <= bank_of(dual_enable, req.addr[ADDR_W-1:ADDR_W-3]);
			end
			if (take && (req.op == PFH_OP_READ)) begin
				page_open <= 1'b1;
				open_page <= req.addr[ADDR_W-1:PAGE_BITS];
			end else if (next_ctl.chip_enable_n || take) begin
				page_open <= 1'b0;
			end
		end
	end
endmodule : pfh_host

`default_nettype wire

/* src/pfh_pkg.sv */
// Purpose: constants and carrier types for the parallel flash host controller
// Assumes: 20 MHz clk; flash is asynchronous and sampled on clk
// Notes: times in ns with derived cycle counts
// Operation
// - read: enable and oe low, we high
// - write: enable and we low, oe high
// - drive accel voltage only while accelerating
// - wait recovery time after reset release
`default_nettype none

package pfh_pkg;
	localparam int CLK_NS = 50;
	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;
	localparam int PAGE_BITS = 3;
	// access times, plain defaults since no figures are given
	localparam int ADDRESS_ACCESS_TIME_NS = 70;
	localparam int ENABLE_ACCESS_TIME_NS = 70;
	localparam int PAGE_ACCESS_TIME_NS = 30;
	localparam int WRITE_PULSE_NS = 60;
	localparam int RESET_PULSE_WIDTH_NS = 500;
	localparam int RESET_RECOVERY_TIME_NS = 200;
	localparam int ACC_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int CE_CYC = (ENABLE_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int PACC_CYC = (PAGE_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC = (RESET_PULSE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RH_CYC = (RESET_RECOVERY_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 8;

	typedef enum logic [1:0] {
		PFH_OP_READ,
		PFH_OP_WRITE,
		PFH_OP_RESET
	} pfh_op_t;

	typedef enum logic [1:0] {
		PFH_BANK_A,
		PFH_BANK_B,
		PFH_BANK_C,
		PFH_BANK_D
	} pfh_bank_t;

	typedef struct packed {
		pfh_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pfh_req_t;

	typedef struct packed {
		logic chip_enable_n;
		logic output_enable_n;
		logic write_enable_n;
		logic reset_n;
	} pfh_ctl_t;
endpackage : pfh_pkg

`default_nettype wire

/* src/pfh_timer.sv */
// Purpose: down counter for flash pin timing
// Assumes: load wins over counting
// Notes: done is high while the count is zero
`default_nettype none

module pfh_timer
	import pfh_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic reset, // async reset
	input wire logic load, // start a new wait
	input wire logic [CNT_W-1:0] cycles, // wait length
	output logic done // wait over
);
	logic [CNT_W-1:0] count;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count <= '0;
		end else if (load) begin
			count <= cycles;
		end else if (count != '0) begin
			count <= count - 8'h01;
		end
	end

	assign done = (count == '0);
endmodule : pfh_timer

`default_nettype wire

/* testbench/pfh_flash_model.sv */
// Purpose: behavioural flash device facing the host
// Assumes: zero access delay; write latched on we rising
// Notes: 00a0 arms one program word, or an erase with 0010; 0090/00f0 enter/leave ident
`default_nettype none
module pfh_flash_model
	import pfh_pkg::*;
#(
	parameter logic [DATA_W-1:0] ID_WORD = 16'h1b2c // arbitrary identification word
)
(
	input wire logic acc_hv, // accel_high_voltage applied
	input wire logic [ADDR_W-1:0] addr, // address
	input wire logic ce_n, // enable
	input wire logic oe_n, // output enable
	input wire logic we_n, // write enable
	input wire logic rst_n, // hw reset
	input wire logic [DATA_W-1:0] din, // write data
	output logic [DATA_W-1:0] dq, // read data
	output logic rb_n // ready/busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DATA_W-1:0] mem [int];
	logic [DATA_W-1:0] rd;
	logic armed = 1'b0;
	logic id_mode = 1'b0;
	always @* begin
		rd = id_mode ? ID_WORD : mem.exists(addr) ? mem[addr] : addr[15:0] ^ 16'h5a5a;
		// undriven pins show the inverse, never a stale word
		dq = (!ce_n && !oe_n && rst_n) ? rd : ~rd;
	end
	always @(posedge we_n or negedge rst_n) begin
		if (!rst_n) begin
			armed = 1'b0;
			id_mode = 1'b0;
			rb_n = 1'b0;
			rb_n <= #300 1'b1;
		end else begin
			if (rst_n === 1'b1 && !ce_n) begin
				if (armed && din == 16'h0010) begin
					mem.delete();
					rb_n = 1'b0;
					rb_n <= #1000 1'b1;
				end else if (armed) begin
					mem[addr] = din;
					rb_n = 1'b0;
					rb_n <= #(acc_hv ? 200 : 1000) 1'b1;
				end
				id_mode = (din == 16'h0090) || (id_mode && din != 16'h00f0);
			end
			armed = (rst_n && !ce_n && !armed && din == 16'h00a0) === 1'b1;
		end
	end
endmodule : pfh_flash_model
`default_nettype wire

/* testbench/pfh_host_asserts.sv */
// Purpose: pin order checks on the flash host
// Assumes: chip enable taken before the half split
// Notes: bound to every pfh_host
`default_nettype none
module pfh_host_asserts
	import pfh_pkg::*;
(
	input wire logic clk, // clock
	input wire logic reset, // async reset
	input wire logic chip_enable_n, // enable
	input wire logic output_enable_n, // oe
	input wire logic write_enable_n, // we
	input wire logic reset_n, // flash reset
	input wire logic accel_enable, // accel select
	input wire logic data_pins_oe // data pins driven
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// four deselected cycles cover the recovery wait
	sequence deselect_s;
		chip_enable_n [*4];
	endsequence
	a_read_levels:
		assert property (!output_enable_n |-> write_enable_n && !chip_enable_n)
		else $error("oe low outside a read");
	a_write_levels:
		assert property (!write_enable_n |-> output_enable_n && !chip_enable_n)
		else $error("we low outside a write");
	a_accel_in_reset:
		assert property (!reset_n [*2] |-> !accel_enable)
		else $error("accel held through reset");
	a_recovery_wait:
		assert property ($rose(reset_n) |-> deselect_s)
		else $error("enable low inside recovery");
	a_drive_on_write:
		assert property (!write_enable_n |-> data_pins_oe)
		else $error("write data not driven");
	a_no_contention:
		assert property (data_pins_oe |-> output_enable_n)
		else $error("data driven while oe low");
endmodule : pfh_host_asserts
bind pfh_host pfh_host_asserts u_pfh_host_asserts (
	.clk(clk), .reset(reset), .chip_enable_n(chip_enable_n),
	.output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
	.reset_n(reset_n), .accel_enable(accel_enable), .data_pins_oe(data_pins_oe)
);
`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: self-checking bench for the flash host
// Assumes: flash model selected by either half enable; model on the pins
// Notes: expected words follow the model's fill pattern, except the programmed 1234 and ID_WORD
`default_nettype none
module tb_top
	import pfh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic req_valid = 1'b0;
	localparam logic [DATA_W-1:0] ID_WORD = 16'h1b2c; // arbitrary identification word
	logic accel_request = 1'b0;
	logic dual_enable = 1'b0;
	time drop_t = 0;
	pfh_req_t req = '0;
	logic req_ready, rsp_valid, busy, ce_n, oe_n, we_n, rst_n, acc, rb_n, lo_n, up_n;
	logic [DATA_W-1:0] rsp_data, dq_out, dq_in;
	logic [ADDR_W-1:0] addr_out;
	logic [1:0] cur_bank;
	int err_count = 0;
	int checks = 0;
	always #25 clk = ~clk;
	pfh_host u_pfh_host (
		.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready), .req(req),
		.dual_enable(dual_enable), .accel_request(accel_request), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .flash_busy(busy), .cur_bank(cur_bank), .addr_out(addr_out),
		.chip_enable_n(ce_n), .lower_half_enable_n(lo_n), .upper_half_enable_n(up_n),
		.output_enable_n(oe_n), .write_enable_n(we_n), .reset_n(rst_n), .accel_enable(acc),
		.data_pins_in(dq_in), .data_pins_out(dq_out), .data_pins_oe(), .ready_busy_n(rb_n)
	);
	pfh_flash_model #(.ID_WORD(ID_WORD)) u_pfh_flash_model (
		.acc_hv(acc),
		.addr(addr_out), .ce_n(lo_n & up_n), .oe_n(oe_n), .we_n(we_n), .rst_n(rst_n),
		.din(dq_out), .dq(dq_in), .rb_n(rb_n)
	);
	task automatic fail(input string m);
		err_count++;
		$display("unexpected at %0t: %s", $time, m);
	endtask : fail
	task automatic print_verdict();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict
	task automatic go(input pfh_op_t op, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic hold);
		int n;
		n = 0;
		// let an edge pass after a release so valid is never rewritten in one step
		if (drop_t == $time) begin
			@(negedge clk);
		end
		req = '{op, a, d};
		req_valid = 1'b1;
		#1;
		while (req_ready !== 1'b1) begin
			n++;
			if (n > 99) begin
				fail("request never taken");
				print_verdict();
			end
			@(negedge clk);
			#1;
		end
		@(negedge clk);
		req_valid = hold;
		if (!hold) begin
			drop_t = $time;
		end
	endtask : go
	// lat counts falling edges from the take to the response
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
		input logic hold, input int lat);
		int n;
		logic [2:0] b;
		logic [1:0] x;
		b = a[22:20];
		go(PFH_OP_READ, a, 16'h0, hold);
		n = 1;
		while (rsp_valid !== 1'b1 && n < 9) begin
			@(negedge clk);
			n++;
		end
		if (rsp_valid !== 1'b1) begin
			fail("no read response");
			print_verdict();
		end
		if (dual_enable) begin
			x = {b[2], b[2] ? (b[1:0] == 2'h3) : (b[1:0] != 2'h0)};
		end else begin
			x = (b == 3'h0) ? 2'h0 : (b == 3'h7) ? 2'h3 : b[2] ? 2'h2 : 2'h1;
		end
		checks += 2;
		if (n != lat || rsp_data !== e) fail("read word or latency");
		if (cur_bank !== x) fail("bank");
	endtask : rd
	task automatic sc_page();
		rd(23'h123450, 16'h6e0a, 1'b1, 4);
		rd(23'h123457, 16'h6e0d, 1'b1, 3);
		rd(23'h123452, 16'h6e08, 1'b0, 3);
		repeat (3) @(negedge clk);
		rd(23'h123453, 16'h6e09, 1'b0, 4);
	endtask : sc_page
	task automatic sc_program();
		int n;
		go(PFH_OP_WRITE, 23'h000008, 16'h00a0, 1'b0);
		go(PFH_OP_WRITE, 23'h000008, 16'h1234, 1'b0);
		rd(23'h700004, 16'h5a5e, 1'b0, 4);
		checks++;
		if (busy !== 1'b1) fail("busy not seen");
		n = 0;
		while (busy !== 1'b0 && n < 60) begin
			@(negedge clk);
			n++;
		end
		if (n == 60) begin
			fail("busy never cleared");
			print_verdict();
		end
		rd(23'h000008, 16'h1234, 1'b0, 4);
	endtask : sc_program
	task automatic sc_reset();
		accel_request = 1'b1;
		go(PFH_OP_WRITE, 23'h200020, 16'h00a0, 1'b0);
		checks++;
		if (acc !== 1'b1) fail("accel not raised");
		go(PFH_OP_RESET, 23'h0, 16'h0, 1'b0);
		accel_request = 1'b0;
		go(PFH_OP_WRITE, 23'h200020, 16'h4321, 1'b0);
		rd(23'h200020, 16'h5a7a, 1'b0, 4);
	endtask : sc_reset
	task automatic sc_ident();
		go(PFH_OP_WRITE, 23'h000555, 16'h0090, 1'b0);
		rd(23'h100001, ID_WORD, 1'b0, 4);
		go(PFH_OP_WRITE, 23'h000000, 16'h00f0, 1'b0);
		go(PFH_OP_WRITE, 23'h000000, 16'h00a0, 1'b0);
		go(PFH_OP_WRITE, 23'h000000, 16'h0010, 1'b0);
		rd(23'h000008, 16'h5a52, 1'b0, 4);
		checks++;
		if (busy !== 1'b1) fail("erase busy not seen");
	endtask : sc_ident
	task automatic sc_dual();
		dual_enable = 1'b1;
		rd(23'h300018, 16'h5a42, 1'b0, 4);
		checks++;
		if (lo_n !== 1'b0 || up_n !== 1'b1) fail("lower half enable");
		rd(23'h700028, 16'h5a72, 1'b0, 4);
		checks++;
		if (lo_n !== 1'b1 || up_n !== 1'b0) fail("upper half enable");
		rd(23'h400008, 16'h5a52, 1'b0, 4);
		dual_enable = 1'b0;
	endtask : sc_dual
	initial begin
		repeat (3) @(negedge clk);
		reset = 1'b0;
		rd(23'h000010, 16'h5a4a, 1'b0, 4);
		sc_page();
		sc_program();
		sc_reset();
		sc_ident();
		sc_dual();
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
